// >>> cam_pkg.sv
// constants for the counter array compare/capture block
// assumes a 32-bit AHB-Lite bus with word-aligned registers
package cam_pkg;

    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int NUM_MOD  = 5;
    localparam int WDOG_MOD = 4;
    localparam int TB_W     = 16;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_MODE     = 8'h04;
    localparam logic [7:0] OFS_TIMEBASE = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_MASK     = 8'h10;
    // per-module block: base + index * stride
    localparam logic [3:0] MOD_BLK_LO   = 4'h2;
    localparam logic [3:0] MOD_BLK_HI   = 4'h6;
    localparam logic [3:0] SUB_MODE     = 4'h0;
    localparam logic [3:0] SUB_CMP_LO   = 4'h4;
    localparam logic [3:0] SUB_CMP_HI   = 4'h8;
    localparam logic [3:0] SUB_DUTY     = 4'hC;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_RUN_BIT  = 0;
    localparam int WATCHDOG_ENABLE_BIT      = 6;
    localparam int STAT_WDOG_BIT = 5;
    localparam int STAT_W        = 6;
    // module_mode_reg, bit 7 reserved and not stored
    localparam int M_IRQ_EN  = 0;
    localparam int M_DUTY    = 1;
    localparam int M_TOGGLE  = 2;
    localparam int M_MATCH   = 3;
    localparam int M_FALL    = 4;
    localparam int M_RISE    = 5;
    localparam int M_COMP    = 6;
    localparam int MODE_W    = 7;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [MODE_W-1:0] MODE_RST = 7'h00;
    localparam logic [TB_W-1:0]   TB_RST   = 16'h0000;
    localparam logic [7:0]        BYTE_MAX = 8'hFF;
    localparam logic [31:0]       RD_ZERO  = 32'h0000_0000;
    localparam logic [1:0]        HRESP_OK = 2'h0;

endpackage : cam_pkg

// >>> cam_unit.sv
// one compare/capture module of the counter array
// assumes timebase and run_tick come from the array on the same clock
`timescale 1ns/10ps
module cam_unit (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           run_tick,
    input  wire logic [cam_pkg::TB_W-1:0]       timebase,
    input  wire logic                           pin_i,
    input  wire logic                           wr_mode,
    input  wire logic                           wr_lo,
    input  wire logic                           wr_hi,
    input  wire logic [7:0]                     wdata,
    output logic      [cam_pkg::MODE_W-1:0]     mode_q,
    output logic      [cam_pkg::TB_W-1:0]       ccap_q,
    output logic      [7:0]                     duty_q,
    output logic                                match_o,
    output logic                                event_o,
    output logic                                pin_o,
    output logic                                pin_oe
);
    logic sync1_q, sync2_q, prev_q;
    logic rise, fall, capture, wrap;
    logic comp_en, duty_mode, toggle_mode;

    // ----------------------------------------
    // pin sampling
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rise    = sync2_q & ~prev_q;
    assign fall    = ~sync2_q & prev_q;
    assign capture = (mode_q[cam_pkg::M_RISE] & rise)
                   | (mode_q[cam_pkg::M_FALL] & fall);

    assign comp_en     = mode_q[cam_pkg::M_COMP];
    assign duty_mode   = comp_en & mode_q[cam_pkg::M_DUTY];
    assign toggle_mode = comp_en & mode_q[cam_pkg::M_MATCH]
                       & mode_q[cam_pkg::M_TOGGLE];
    // full 16-bit equality, once per increment
    assign match_o = run_tick & comp_en & (timebase == ccap_q);
    assign event_o = capture | (match_o & mode_q[cam_pkg::M_MATCH]);
    assign wrap    = run_tick & (timebase[7:0] == cam_pkg::BYTE_MAX);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= cam_pkg::MODE_RST;
        end else if (wr_mode) begin
            mode_q <= wdata[cam_pkg::MODE_W-1:0];
        end
    end

    // capture beats a software write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ccap_q <= cam_pkg::TB_RST;
        end else if (capture) begin
            ccap_q <= timebase;
        end else begin
            if (wr_lo) begin
                ccap_q[7:0] <= wdata;
            end
            if (wr_hi) begin
                ccap_q[15:8] <= wdata;
            end
        end
    end

    // active duty only follows the reload byte at wrap: no glitch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_q <= 8'h00;
        end else if (wrap) begin
            duty_q <= ccap_q[15:8];
        end
    end

    // ----------------------------------------
    // output pin
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_o <= 1'b0;
        end else if (duty_mode) begin
            pin_o <= (timebase[7:0] >= duty_q);
        end else if (toggle_mode && match_o) begin
            pin_o <= ~pin_o;
        end
    end

    assign pin_oe = duty_mode | toggle_mode;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CAPTURE: assert property (capture |=> ccap_q == $past(timebase))
        else $error("capture did not copy the time base");
    AST_TOGGLE: assert property (toggle_mode && match_o && !duty_mode
                                 |=> pin_o != $past(pin_o))
        else $error("toggle output missed a match");
    AST_PWM_LEVEL: assert property (duty_mode |=>
                       pin_o == ($past(timebase[7:0]) >= $past(duty_q)))
        else $error("duty output level wrong");
    AST_RELOAD: assert property (wrap |=> duty_q == $past(ccap_q[15:8]))
        else $error("duty byte not reloaded at wrap");

endmodule : cam_unit

// >>> cam_top.sv
// counter array: shared time base, five compare/capture modules,
// watchdog on module 4, AHB-Lite register slave, one interrupt line
// assumes a single master and hready driven from this slave alone
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module cam_top (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    input  wire logic [cam_pkg::NUM_MOD-1:0]  module_pin_i,
    output logic      [cam_pkg::NUM_MOD-1:0]  module_pin_o,
    output logic      [cam_pkg::NUM_MOD-1:0]  module_pin_oe,
    output logic                              irq,
    output logic                              wdog_reset
);
    localparam int N = cam_pkg::NUM_MOD;
    localparam int W = cam_pkg::WDOG_MOD;

    logic                  run_q;
    logic                  watchdog_enable_q;
    logic [15:0]           tb_q;
    logic [cam_pkg::STAT_W-1:0] status_q, mask_q, stat_set, stat_req;
    logic                  wdog_q;
    logic                  run_tick;

    // bus phase capture
    logic                  wr_pend_q;
    logic [7:0]            wr_addr_q;
    logic                  addr_ok;

    // decoded write strobes
    logic                  wr_ctrl, wr_mode_reg, wr_tb, wr_stat, wr_mask;
    logic [N-1:0]          wr_mmode, wr_lo, wr_hi;
    logic [3:0]            wr_blk, wr_sub;

    // per-module views
    logic [cam_pkg::MODE_W-1:0] mode   [N];
    logic [15:0]                ccap   [N];
    logic [7:0]                 duty   [N];
    logic [N-1:0]               match, evt;

    logic                  wdog_hit;
    logic [31:0]           rd_d;
    logic [3:0]            rd_blk, rd_sub;
    logic [2:0]            rd_idx;

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    // no wait states needed: every register answers in one cycle
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel & hready & htrans[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    assign wr_blk = wr_addr_q[7:4];
    assign wr_sub = wr_addr_q[3:0];

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    always_comb begin
        wr_ctrl     = 1'b0;
        wr_mode_reg = 1'b0;
        wr_tb       = 1'b0;
        wr_stat     = 1'b0;
        wr_mask     = 1'b0;
        if (!wr_pend_q) begin
            wr_ctrl = 1'b0;
        end else if (wr_addr_q == cam_pkg::OFS_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (wr_addr_q == cam_pkg::OFS_MODE) begin
            wr_mode_reg = 1'b1;
        end else if (wr_addr_q == cam_pkg::OFS_TIMEBASE) begin
            wr_tb = 1'b1;
        end else if (wr_addr_q == cam_pkg::OFS_STATUS) begin
            wr_stat = 1'b1;
        end else if (wr_addr_q == cam_pkg::OFS_MASK) begin
            wr_mask = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_mod
            localparam logic [3:0] BLK = cam_pkg::MOD_BLK_LO + 4'(g);
            logic hit;
            assign hit = wr_pend_q & (wr_blk == BLK);
            assign wr_mmode[g] = hit & (wr_sub == cam_pkg::SUB_MODE);
            assign wr_lo[g]    = hit & (wr_sub == cam_pkg::SUB_CMP_LO);
            assign wr_hi[g]    = hit & (wr_sub == cam_pkg::SUB_CMP_HI);

            cam_unit u_unit (
                .clk      (clk),
                .rst_n    (rst_n),
                .run_tick (run_tick),
                .timebase (tb_q),
                .pin_i    (module_pin_i[g]),
                .wr_mode  (wr_mmode[g]),
                .wr_lo    (wr_lo[g]),
                .wr_hi    (wr_hi[g]),
                .wdata    (hwdata[7:0]),
                .mode_q   (mode[g]),
                .ccap_q   (ccap[g]),
                .duty_q   (duty[g]),
                .match_o  (match[g]),
                .event_o  (evt[g]),
                .pin_o    (module_pin_o[g]),
                .pin_oe   (module_pin_oe[g])
            );

            assign stat_set[g] = evt[g];
            // flag and per-module enable both needed
            assign stat_req[g] = status_q[g] & mode[g][cam_pkg::M_IRQ_EN];
        end
    endgenerate

    // ----------------------------------------
    // control and shared time base
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (wr_ctrl) begin
            run_q <= hwdata[cam_pkg::CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_enable_q <= 1'b0;
        end else if (wr_mode_reg) begin
            watchdog_enable_q <= hwdata[cam_pkg::WATCHDOG_ENABLE_BIT];
        end
    end

    // one increment per clock while running; shared by all modules
    assign run_tick = run_q & ~wr_tb;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tb_q <= cam_pkg::TB_RST;
        end else if (wr_tb) begin
            tb_q <= hwdata[15:0];
        end else if (run_tick) begin
            tb_q <= tb_q + 16'h0001;
        end
    end

    // ----------------------------------------
    // watchdog, module 4 only
    // ----------------------------------------
    // compare mode plus enable; other modes untouched
    assign wdog_hit = watchdog_enable_q & match[W] & mode[W][cam_pkg::M_MATCH];

    // registered pulse, driven out on the wdog_reset output port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_q <= 1'b0;
        end else begin
            wdog_q <= wdog_hit;
        end
    end
    assign wdog_reset = wdog_q;

    // ----------------------------------------
    // status, mask, interrupt
    // ----------------------------------------
    assign stat_set[cam_pkg::STAT_WDOG_BIT] = wdog_hit;
    assign stat_req[cam_pkg::STAT_WDOG_BIT] =
        status_q[cam_pkg::STAT_WDOG_BIT];

    // set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~({cam_pkg::STAT_W{wr_stat}}
                        & hwdata[cam_pkg::STAT_W-1:0])) | stat_set;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= '0;
        end else if (wr_mask) begin
            mask_q <= hwdata[cam_pkg::STAT_W-1:0];
        end
    end

    assign irq = |(stat_req & mask_q);

    // ----------------------------------------
    // read mux, registered into the data phase
    // ----------------------------------------
    assign rd_blk = haddr[7:4];
    assign rd_sub = haddr[3:0];
    assign rd_idx = 3'(rd_blk - cam_pkg::MOD_BLK_LO);

    always_comb begin
        rd_d = cam_pkg::RD_ZERO;
        if (haddr[7:0] == cam_pkg::OFS_CTRL) begin
            rd_d[cam_pkg::CTRL_RUN_BIT] = run_q;
        end else if (haddr[7:0] == cam_pkg::OFS_MODE) begin
            rd_d[cam_pkg::WATCHDOG_ENABLE_BIT] = watchdog_enable_q;
        end else if (haddr[7:0] == cam_pkg::OFS_TIMEBASE) begin
            rd_d[15:0] = tb_q;
        end else if (haddr[7:0] == cam_pkg::OFS_STATUS) begin
            rd_d[cam_pkg::STAT_W-1:0] = status_q;
        end else if (haddr[7:0] == cam_pkg::OFS_MASK) begin
            rd_d[cam_pkg::STAT_W-1:0] = mask_q;
        end else if (rd_blk >= cam_pkg::MOD_BLK_LO
                     && rd_blk <= cam_pkg::MOD_BLK_HI) begin
            // reserved mode bit 7 reads zero
            if (rd_sub == cam_pkg::SUB_MODE) begin
                rd_d[cam_pkg::MODE_W-1:0] = mode[rd_idx];
            end else if (rd_sub == cam_pkg::SUB_CMP_LO) begin
                rd_d[7:0] = ccap[rd_idx][7:0];
            end else if (rd_sub == cam_pkg::SUB_CMP_HI) begin
                rd_d[7:0] = ccap[rd_idx][15:8];
            end else if (rd_sub == cam_pkg::SUB_DUTY) begin
                rd_d[7:0] = duty[rd_idx];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= cam_pkg::RD_ZERO;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wd_armed;
        watchdog_enable_q && mode[W][cam_pkg::M_COMP] && mode[W][cam_pkg::M_MATCH];
    endsequence
    sequence s_wd_match;
        run_tick && tb_q == ccap[W];
    endsequence

    AST_WDOG_FIRE: assert property (s_wd_armed and s_wd_match
                                    |=> wdog_reset)
        else $error("watchdog match gave no internal reset");
    AST_WDOG_OFF: assert property (!watchdog_enable_q |=> !wdog_reset)
        else $error("watchdog reset while disabled");
    AST_FLAG_STICKY: assert property (status_q[0] && !wr_stat
                                      |=> status_q[0])
        else $error("event flag cleared by hardware");
    AST_SET_WINS: assert property (evt[1] |=> status_q[1])
        else $error("event lost against clear");
    AST_IRQ: assert property (status_q[2] && mode[2][cam_pkg::M_IRQ_EN]
                              && mask_q[2] |-> irq)
        else $error("interrupt not raised");
    AST_TIMER_FLAG: assert property (match[3] && mode[3][cam_pkg::M_MATCH]
                                     |=> status_q[3])
        else $error("timer match did not set flag");
    AST_MATCH_EQ: assert property (run_tick && mode[W][cam_pkg::M_COMP]
                                   && mode[W][cam_pkg::M_MATCH]
                                   && tb_q == ccap[W]
                                   |=> status_q[W])
        else $error("16-bit equality did not flag a match");
    AST_TB_STEP: assert property (run_tick |=> tb_q == $past(tb_q) + 16'h0001)
        else $error("time base did not advance");

endmodule : cam_top

// >>> cam_pin_model.sv
// far-side model of the counter array's external module pins
// assumes the block's pin outputs and enables settle after clk edges
`timescale 1ns/10ps
module cam_pin_model (
    input  wire logic                        clk,
    input  wire logic [cam_pkg::NUM_MOD-1:0] pin_o,
    input  wire logic [cam_pkg::NUM_MOD-1:0] pin_oe,
    output logic      [cam_pkg::NUM_MOD-1:0] pin_i
);
    logic [cam_pkg::NUM_MOD-1:0] ext_q;

    // wire level: the block wins on any pin it drives
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_q);

    initial ext_q = 5'h00;

    // change one pin just after a rising edge
    task automatic drive(input int idx, input logic v);
        @(posedge clk);
        ext_q[idx] <= v;
    endtask : drive
endmodule : cam_pin_model

// >>> tb_top.sv
// self-checking bench for the counter array over AHB-Lite
// assumes zero-wait slave; hready is fed back from hreadyout
`timescale 1ns/10ps
module tb_top;
    logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic        irq, wdog_reset;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [4:0]  pin_i, pin_o, pin_oe;
    int          miscompares, checked;

    assign hready = hreadyout;

    cam_top DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .module_pin_i(pin_i), .module_pin_o(pin_o),
        .module_pin_oe(pin_oe), .irq(irq), .wdog_reset(wdog_reset));

    cam_pin_model u_pins (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_i(pin_i));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task automatic end_of_test();
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            $display("[ERR] %0t bus hang", $time);
            end_of_test();
        end
    endtask : wait_rdy

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] unused;
        bus(a, 1'b1, wd, unused);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(a, 1'b0, 32'h0000_0000, d);
        chk(d, exp);
        chk(hresp, 1'b0);
    endtask : rd_chk

    // count watchdog pulses over a fixed window
    task automatic wd_count(output int p);
        p = 0;
        repeat (40) begin
            @(negedge clk);
            if (wdog_reset === 1'b1) p++;
        end
    endtask : wd_count

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int          m, p;
        logic [7:0]  b, base;
        miscompares = 0;
        checked = 0;
        rst_n = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; haddr = 32'h0000_0000; hwdata = 32'h0000_0000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h20, 32'h0000_0000);
        rd_chk(8'h0C, 32'h0000_0000);
        rd_chk(8'hFC, 32'h0000_0000);
        // capture: rise only, fall only, both edges on modules 0..2
        for (m = 0; m < 3; m++) begin
            b = (m == 0) ? 8'h21 : (m == 1) ? 8'h11 : 8'h31;
            base = 8'h20 + 8'(m * 16);
            u_pins.drive(m, 1'b1);
            wr(base, {24'h00_0000, b});
            wr(8'h08, 32'h0000_1200 + m);
            u_pins.drive(m, 1'b0);
            repeat (6) @(posedge clk);
            rd_chk(8'h0C, (m != 0) ? (32'h1 << m) : 32'h0);
            wr(8'h08, 32'h0000_3400 + m);
            u_pins.drive(m, 1'b1);
            repeat (6) @(posedge clk);
            rd_chk(8'h0C, 32'h1 << m);
            rd_chk(base + 8'h04, m);
            rd_chk(base + 8'h08, (m == 1) ? 32'h12 : 32'h34);
            wr(8'h10, 32'h1 << m);
            @(negedge clk);
            chk(irq, 1'b1);
            wr(8'h0C, 32'h1 << m);
            @(negedge clk);
            chk(irq, 1'b0);
            wr(8'h10, 32'h0000_0000);
        end
        // high-speed output on module 1
        wr(8'h30, 32'h0000_004C);
        wr(8'h34, 32'h0000_0080);
        wr(8'h38, 32'h0000_0000);
        for (m = 0; m < 2; m++) begin
            wr(8'h08, 32'h0000_0070);
            wr(8'h00, 32'h0000_0001);
            repeat (40) @(posedge clk);
            wr(8'h00, 32'h0000_0000);
            @(negedge clk);
            chk({pin_oe[1], pin_o[1]}, {1'b1, m == 0});
        end
        // duty output on module 2 with reload at the low-byte wrap
        wr(8'h40, 32'h0000_0042);
        wr(8'h48, 32'h0000_0040);
        wr(8'h08, 32'h0000_00F8);
        wr(8'h00, 32'h0000_0001);
        repeat (20) @(posedge clk);
        wr(8'h00, 32'h0000_0000);
        rd_chk(8'h4C, 32'h0000_0040);
        wr(8'h08, 32'h0000_0010);
        repeat (3) @(negedge clk);
        chk(pin_o[2], 1'b0);
        wr(8'h08, 32'h0000_0040);
        repeat (3) @(negedge clk);
        chk(pin_o[2], 1'b1);
        // module 4 timer, watchdog off then on
        wr(8'h0C, 32'h0000_003F);
        wr(8'h60, 32'h0000_0048);
        wr(8'h64, 32'h0000_0020);
        wr(8'h68, 32'h0000_0000);
        for (m = 0; m < 2; m++) begin
            wr(8'h04, (m == 1) ? 32'h0000_0040 : 32'h0000_0000);
            wr(8'h08, 32'h0000_0010);
            wr(8'h00, 32'h0000_0001);
            wd_count(p);
            wr(8'h00, 32'h0000_0000);
            chk(p, m);
            chk(pin_oe[4], 1'b0);
            rd_chk(8'h0C, (m == 1) ? 32'h30 : 32'h10);
            wr(8'h0C, 32'h0000_003F);
        end
        end_of_test();
    end
endmodule : tb_top
